// [rtl/quad_dac_pkg.sv]
// Constants for the quad DAC serial load controller
package quad_dac_pkg;

	// Serial word layout
	localparam int WORD_BITS = 16;
	localparam int CHAN_HI_POS = 15;
	localparam int CHAN_LO_POS = 14;
	localparam int PWR_N_POS = 13;
	localparam int LOAD_N_POS = 12;
	localparam int DATA_MSB_POS = 11;
	localparam int DATA_FIELD_BITS = 12;
	localparam int NUM_CHANNELS = 4;
	localparam logic [4:0] LAST_BIT_IDX = 5'h0F;

	// APB register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] LAST_WORD_OFS = 8'h08;
	localparam logic [7:0] WORD_COUNT_OFS = 8'h0C;
	localparam logic [7:0] ABORT_COUNT_OFS = 8'h10;
	localparam logic [7:0] INPUT_BASE_OFS = 8'h20;
	localparam logic [7:0] OUTPUT_BASE_OFS = 8'h30;

	// Control register fields and reset values
	localparam int CTRL_LINK_EN_POS = 0;
	localparam logic CTRL_LINK_EN_RST = 1'b1;

	// Status register fields
	localparam int STAT_PWR_DOWN_POS = 0;
	localparam int STAT_STAGE_EN_POS = 1;
	localparam int STAT_WORD_DONE_POS = 2;
	localparam int STAT_DIRTY_POS = 4;

	// Reset values of the datapath
	localparam logic PWR_DOWN_RST = 1'b0;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [15:0] COUNT_RST = 16'h0000;

	// Link receive states
	typedef enum logic [1:0] {
		LINK_IDLE = 2'b00,
		LINK_ARMED = 2'b01,
		LINK_DONE = 2'b11
	} link_state_t;

endpackage

// [rtl/quad_dac_serial_load_control.sv]
// Serial load front end of a quad DAC with APB status and control
//
// Operation
// - Sixteen bit word, most significant bit first
// - Top two bits select channel A to D
// - Bit 13 low powers down all channels
// - Bit 12 low updates all outputs together
// - Bit 12 high writes input register only
// - Narrow variants ignore the lowest data bits
// - Codes are straight binary
// - Data accepted only while frame is low
// - Shift on serial clock falling edges, sixteen
// - Ignore everything after sixteenth edge until reframe
// - Completed word loads addressed input register
// - Early frame rise aborts, registers unchanged
// - Input stage enabled on frame fall only
// - Each channel has input and output register
// - Simultaneous update only refreshes written channels
// - Power-down leaves register contents unchanged
// - Reset clears registers, selects normal operation
`timescale 1ns/1ps

module quad_dac_serial_load_control
	import quad_dac_pkg::*;
#(
	parameter int RES_BITS = 12
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial link pins
	input wire logic frame_n_pin,
	input wire logic sclk_pin,
	input wire logic sdata_pin,
	// Converter side
	output logic [RES_BITS-1:0] out_code_a,
	output logic [RES_BITS-1:0] out_code_b,
	output logic [RES_BITS-1:0] out_code_c,
	output logic [RES_BITS-1:0] out_code_d,
	output logic power_down,
	output logic input_stage_en
);

	////////////////////////////////////////////////////////////////////////
	// Field helpers

	function automatic logic [1:0] chan_of(input logic [15:0] w);
		chan_of = {w[CHAN_HI_POS], w[CHAN_LO_POS]};
	endfunction

	function automatic logic [RES_BITS-1:0] code_of(input logic [15:0] w);
		code_of = w[DATA_MSB_POS -: RES_BITS];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic frame_s1_reg, frame_s2_reg, frame_s3_reg;
	logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
	logic sdata_s1_reg, sdata_s2_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_s1_reg <= 1'b1;
			frame_s2_reg <= 1'b1;
			frame_s3_reg <= 1'b1;
			sclk_s1_reg <= 1'b0;
			sclk_s2_reg <= 1'b0;
			sclk_s3_reg <= 1'b0;
			sdata_s1_reg <= 1'b0;
			sdata_s2_reg <= 1'b0;
		end else begin
			frame_s1_reg <= frame_n_pin;
			frame_s2_reg <= frame_s1_reg;
			frame_s3_reg <= frame_s2_reg;
			sclk_s1_reg <= sclk_pin;
			sclk_s2_reg <= sclk_s1_reg;
			sclk_s3_reg <= sclk_s2_reg;
			sdata_s1_reg <= sdata_pin;
			sdata_s2_reg <= sdata_s1_reg;
		end
	end

	logic frame_fall, frame_rise, sclk_fall;
	assign frame_fall = frame_s3_reg & ~frame_s2_reg;
	assign frame_rise = ~frame_s3_reg & frame_s2_reg;
	assign sclk_fall = sclk_s3_reg & ~sclk_s2_reg;

	////////////////////////////////////////////////////////////////////////
	// Link state and shift register

	link_state_t link_state_reg, link_state_next;
	logic link_en_reg;
	logic [4:0] bit_cnt_reg;
	logic [15:0] shift_reg;
	logic [15:0] word_next;
	logic shift_en, word_done, abort;

	// Frame low and stage enabled, or enabled this very cycle
	assign shift_en = sclk_fall & ~frame_s2_reg &
		((link_state_reg == LINK_ARMED) | (frame_fall & link_en_reg));
	assign word_done = shift_en & (link_state_reg == LINK_ARMED) & (bit_cnt_reg == LAST_BIT_IDX);
	assign abort = frame_rise & (link_state_reg == LINK_ARMED);
	assign word_next = {shift_reg[WORD_BITS-2:0], sdata_s2_reg};

	always_comb begin
		link_state_next = link_state_reg;
		case (link_state_reg)
			LINK_IDLE: begin
				if (frame_fall && link_en_reg) begin
					link_state_next = word_done ? LINK_DONE : LINK_ARMED;
				end
			end
			LINK_ARMED: begin
				if (frame_rise) begin
					link_state_next = LINK_IDLE;
				end else if (word_done) begin
					link_state_next = LINK_DONE;
				end
			end
			LINK_DONE: begin
				if (frame_rise) begin
					link_state_next = LINK_IDLE;
				end
			end
			default: begin
				link_state_next = LINK_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_state_reg <= LINK_IDLE;
		end else begin
			link_state_reg <= link_state_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_cnt_reg <= 5'h00;
			shift_reg <= WORD_RST;
		end else if (frame_fall) begin
			bit_cnt_reg <= shift_en ? 5'h01 : 5'h00;
			shift_reg <= shift_en ? word_next : WORD_RST;
		end else if (shift_en) begin
			bit_cnt_reg <= bit_cnt_reg + 5'h01;
			shift_reg <= word_next;
		end
	end

	assign input_stage_en = (link_state_reg == LINK_ARMED);

	////////////////////////////////////////////////////////////////////////
	// Double-buffered channel registers

	logic [RES_BITS-1:0] in_reg [NUM_CHANNELS];
	logic [RES_BITS-1:0] out_reg [NUM_CHANNELS];
	logic [NUM_CHANNELS-1:0] dirty_reg;
	logic power_down_reg;
	logic [1:0] word_chan;
	logic [RES_BITS-1:0] word_code;

	assign word_chan = chan_of(word_next);
	assign word_code = code_of(word_next);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_CHANNELS; i++) begin
				in_reg[i] <= '0;
				out_reg[i] <= '0;
			end
			dirty_reg <= '0;
		end else if (word_done) begin
			for (int i = 0; i < NUM_CHANNELS; i++) begin
				if (word_chan == 2'(i)) begin
					in_reg[i] <= word_code;
				end
				if (!word_next[LOAD_N_POS]) begin
					if (word_chan == 2'(i)) begin
						out_reg[i] <= word_code;
					end else if (dirty_reg[i]) begin
						out_reg[i] <= in_reg[i];
					end
					dirty_reg[i] <= 1'b0;
				end else if (word_chan == 2'(i)) begin
					dirty_reg[i] <= 1'b1;
				end
			end
		end
	end

	// Only the mode flag moves; codes stay put
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_down_reg <= PWR_DOWN_RST;
		end else if (word_done) begin
			power_down_reg <= ~word_next[PWR_N_POS];
		end
	end

	assign out_code_a = out_reg[0];
	assign out_code_b = out_reg[1];
	assign out_code_c = out_reg[2];
	assign out_code_d = out_reg[3];
	assign power_down = power_down_reg;

	////////////////////////////////////////////////////////////////////////
	// Statistics

	logic [15:0] last_word_reg, word_count_reg, abort_count_reg;
	logic word_done_seen_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_word_reg <= WORD_RST;
			word_count_reg <= COUNT_RST;
			abort_count_reg <= COUNT_RST;
		end else begin
			if (word_done) begin
				last_word_reg <= word_next;
				word_count_reg <= word_count_reg + 16'h0001;
			end
			if (abort) begin
				abort_count_reg <= abort_count_reg + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB slave

	logic apb_setup, apb_write;
	logic status_rd;
	assign apb_setup = psel & ~penable;
	assign apb_write = psel & penable & pwrite;
	assign status_rd = apb_setup & ~pwrite & (paddr == STATUS_OFS);
	assign pready = 1'b1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_en_reg <= CTRL_LINK_EN_RST;
		end else if (apb_write && paddr == CTRL_OFS) begin
			link_en_reg <= pwdata[CTRL_LINK_EN_POS];
		end
	end

	// Sticky completion flag; a new word wins over the read clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			word_done_seen_reg <= 1'b0;
		end else if (word_done) begin
			word_done_seen_reg <= 1'b1;
		end else if (status_rd) begin
			word_done_seen_reg <= 1'b0;
		end
	end

	function automatic logic [32:0] read_mux(input logic [7:0] a);
		logic [32:0] r;
		r = 33'h000000000;
		case (a)
			CTRL_OFS: r[CTRL_LINK_EN_POS] = link_en_reg;
			STATUS_OFS: begin
				r[STAT_PWR_DOWN_POS] = power_down_reg;
				r[STAT_STAGE_EN_POS] = input_stage_en;
				r[STAT_WORD_DONE_POS] = word_done_seen_reg;
				r[STAT_DIRTY_POS +: NUM_CHANNELS] = dirty_reg;
			end
			LAST_WORD_OFS: r[15:0] = last_word_reg;
			WORD_COUNT_OFS: r[15:0] = word_count_reg;
			ABORT_COUNT_OFS: r[15:0] = abort_count_reg;
			default: begin
				if (a[7:4] == INPUT_BASE_OFS[7:4] && a[3:2] != 2'b00 || a == INPUT_BASE_OFS) begin
					r[RES_BITS-1:0] = in_reg[a[3:2]];
				end else if (a[7:4] == OUTPUT_BASE_OFS[7:4] && a[1:0] == 2'b00) begin
					r[RES_BITS-1:0] = out_reg[a[3:2]];
				end else begin
					r[32] = 1'b1;
				end
			end
		endcase
		if (a[7:4] == INPUT_BASE_OFS[7:4] && a[1:0] != 2'b00) begin
			r = 33'h100000000;
		end
		read_mux = r;
	endfunction

	logic [32:0] rd_word;
	assign rd_word = read_mux(paddr);

	// Answer prepared in setup, presented in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (apb_setup) begin
			prdata <= pwrite ? 32'h00000000 : rd_word[31:0];
			pslverr <= rd_word[32];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	logic [RES_BITS*NUM_CHANNELS-1:0] in_flat, out_flat;
	assign in_flat = {in_reg[3], in_reg[2], in_reg[1], in_reg[0]};
	assign out_flat = {out_reg[3], out_reg[2], out_reg[1], out_reg[0]};

	sequence s_frame_open;
		frame_fall && link_en_reg && !sclk_fall && link_state_reg == LINK_IDLE;
	endsequence

	sequence s_stage_up;
		##1 input_stage_en;
	endsequence

	AST_STAGE_ARM: assert property (@(posedge pclk) disable iff (!presetn)
		s_frame_open |-> s_stage_up)
		else $error("input stage not enabled after frame fall");

	AST_COMMIT: assert property (@(posedge pclk) disable iff (!presetn)
		word_done |=> in_reg[$past(word_chan)] == $past(word_code))
		else $error("completed word not in input register");

	AST_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
		abort |=> $stable(in_flat) && $stable(out_flat) && link_state_reg == LINK_IDLE)
		else $error("aborted frame changed registers");

	AST_HOLD_OUT: assert property (@(posedge pclk) disable iff (!presetn)
		word_done && word_next[LOAD_N_POS] |=> $stable(out_flat) && dirty_reg[$past(word_chan)])
		else $error("outputs moved with load bit high");

	AST_SIM_UPDATE: assert property (@(posedge pclk) disable iff (!presetn)
		word_done && !word_next[LOAD_N_POS] |=> out_reg[$past(word_chan)] == $past(word_code)
			&& dirty_reg == '0)
		else $error("simultaneous update missed addressed channel");

	AST_CLEAN_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
		word_done && !dirty_reg[0] && word_chan != 2'b00 |=> $stable(out_reg[0]))
		else $error("clean channel refreshed");

	AST_PWR: assert property (@(posedge pclk) disable iff (!presetn)
		word_done |=> power_down == !$past(word_next[PWR_N_POS]))
		else $error("power mode not taken from word");

	AST_IGNORE: assert property (@(posedge pclk) disable iff (!presetn)
		link_state_reg == LINK_DONE && !frame_fall |=> $stable(shift_reg) && $stable(in_flat))
		else $error("data taken after sixteenth edge");

	AST_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
		shift_en && !frame_fall |=> bit_cnt_reg == $past(bit_cnt_reg) + 5'h01)
		else $error("bit count did not advance");

endmodule

// [test/serial_host_model.sv]
// Serial master model driving the three link pins
`timescale 1ns/1ps

module serial_host_model (
	// Link pins
	output logic frame_n,
	output logic sclk,
	output logic sdata
);
	initial begin
		frame_n = 1'b1;
		sclk = 1'b0;
		sdata = 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// One frame of n falling edges, optional pause after a byte
	task automatic send(input logic [15:0] w, input int n, input bit split);
		#7;
		frame_n = 1'b0;
		#250;
		for (int i = 0; i < n; i++) begin
			sclk = 1'b1;
			sdata = w[15 - (i % 16)];
			#100;
			sclk = 1'b0;
			#100;
			if (split && i == 7) #400;
		end
		#100;
		frame_n = 1'b1;
		sdata = ~sdata;
	endtask
endmodule

// [test/testbench.sv]
// Self-checking testbench for the quad DAC serial load controller
`timescale 1ns/1ps

module testbench;
	import quad_dac_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic frame_n_pin;
	logic sclk_pin;
	logic sdata_pin;
	logic [11:0] out_code_a, out_code_b, out_code_c, out_code_d;
	logic power_down;
	logic input_stage_en;
	logic [47:0] outs;
	int bad_count = 0;
	int total_checks = 0;
	int cycles = 0;

	assign outs = {out_code_a, out_code_b, out_code_c, out_code_d};
	always #12.5 pclk = ~pclk;

	quad_dac_serial_load_control #(.RES_BITS(12)) i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .frame_n_pin(frame_n_pin),
		.sclk_pin(sclk_pin), .sdata_pin(sdata_pin), .out_code_a(out_code_a),
		.out_code_b(out_code_b), .out_code_c(out_code_c), .out_code_d(out_code_d),
		.power_down(power_down), .input_stage_en(input_stage_en)
	);

	serial_host_model i_host (.frame_n(frame_n_pin), .sclk(sclk_pin), .sdata(sdata_pin));

	////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic end_sim();
		if (bad_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic ee, input string nm);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk(nm, {32'h0, exp}, {32'h0, q});
		chk("pslverr", {63'h0, ee}, {63'h0, e});
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic tx(input logic [15:0] w, input int n, input bit split);
		i_host.send(w, n, split);
		repeat (6) @(posedge pclk);
	endtask

	////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		chk("outs", 64'h0, {16'h0, outs});
		chk("power_down", 64'h0, {63'h0, power_down});
		chk("stage_en", 64'h0, {63'h0, input_stage_en});
		rd(CTRL_OFS, 32'h1, 1'b0, "ctrl");
		rd(8'h40, 32'h0, 1'b1, "unmapped");
	endtask

	task automatic t_input_only();
		tx(16'h7A5C, 16, 1'b0);
		rd(INPUT_BASE_OFS + 8'h04, 32'hA5C, 1'b0, "in_b");
		chk("outs", 64'h0, {16'h0, outs});
		rd(STATUS_OFS, 32'h24, 1'b0, "status");
	endtask

	task automatic t_simul();
		tx(16'h3123, 16, 1'b0);
		tx(16'hB456, 16, 1'b0);
		chk("outs", 64'h0, {16'h0, outs});
		fork
			tx(16'hEFFF, 16, 1'b0);
			begin
				#1010;
				chk("stage_en", 64'h1, {63'h0, input_stage_en});
			end
		join
		chk("stage_en", 64'h0, {63'h0, input_stage_en});
		chk("outs", 64'h123A5C456FFF, {16'h0, outs});
		rd(OUTPUT_BASE_OFS + 8'h0C, 32'hFFF, 1'b0, "out_d");
		rd(STATUS_OFS, 32'h04, 1'b0, "status");
	endtask

	task automatic t_power();
		tx(16'h5111, 16, 1'b0);
		chk("power_down", 64'h1, {63'h0, power_down});
		chk("outs", 64'h123A5C456FFF, {16'h0, outs});
		rd(INPUT_BASE_OFS + 8'h04, 32'h111, 1'b0, "in_b");
		rd(STATUS_OFS, 32'h25, 1'b0, "status");
		tx(16'h6222, 16, 1'b0);
		chk("power_down", 64'h0, {63'h0, power_down});
		chk("outs", 64'h123222456FFF, {16'h0, outs});
	endtask

	task automatic t_abort_extra();
		tx(16'h3777, 10, 1'b0);
		rd(INPUT_BASE_OFS, 32'h123, 1'b0, "in_a");
		tx(16'h30F0, 20, 1'b0);
		rd(INPUT_BASE_OFS, 32'h0F0, 1'b0, "in_a");
		rd(ABORT_COUNT_OFS, 32'h1, 1'b0, "abort_count");
		rd(WORD_COUNT_OFS, 32'h7, 1'b0, "word_count");
		rd(LAST_WORD_OFS, 32'h30F0, 1'b0, "last_word");
		chk("outs", 64'h123222456FFF, {16'h0, outs});
	endtask

	task automatic t_byte_host();
		tx(16'hE9AB, 16, 1'b1);
		chk("outs", 64'h0F02224569AB, {16'h0, outs});
	endtask

	task automatic t_link_off();
		wr(CTRL_OFS, 32'h0);
		tx(16'hB333, 16, 1'b0);
		rd(INPUT_BASE_OFS + 8'h08, 32'h456, 1'b0, "in_c");
		wr(CTRL_OFS, 32'h1);
		tx(16'hB333, 16, 1'b0);
		rd(INPUT_BASE_OFS + 8'h08, 32'h333, 1'b0, "in_c");
	endtask

	task automatic t_reset_mid();
		wr(CTRL_OFS, 32'h0);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("outs", 64'h0, {16'h0, outs});
		rd(CTRL_OFS, 32'h1, 1'b0, "ctrl");
		rd(INPUT_BASE_OFS + 8'h08, 32'h0, 1'b0, "in_c");
	endtask

	////////////////////////////////////////////////////////////////
	// Timeout and main sequence
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 8000) begin
			bad_count++;
			end_sim();
		end
	end

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		t_reset();
		t_input_only();
		t_simul();
		t_power();
		t_abort_extra();
		t_byte_host();
		t_link_off();
		t_reset_mid();
		end_sim();
	end
endmodule
